/* File: core/svcrc_ctrl.sv */
// second virtual channel resource control register and its negotiation logic
`timescale 1ns/1ns
`include "svcrc_params.svh"
module svcrc_ctrl #(
    parameter int PHASES     = 128,
    parameter int PHASE_BITS = 4
) (
    // clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_reset,
    // extended configuration access
    input  wire logic                          i_cfg_wr,
    input  wire logic                          i_cfg_rd,
    input  wire logic [11:0]                   i_cfg_addr,
    input  wire logic [3:0]                    i_cfg_be,
    input  wire logic [31:0]                   i_cfg_wdata,
    output logic      [31:0]                   o_cfg_rdata,
    // link negotiation
    output logic                               o_neg_start,
    input  wire logic                          i_neg_done,
    // port arbitration tables
    input  wire logic                          i_table_modified,
    input  wire logic [PHASES*PHASE_BITS-1:0]  i_shadow_table,
    output logic      [PHASES*PHASE_BITS-1:0]  o_active_table,
    // decoded control
    output svcrc_pkg::svcrc_ctrl_s             o_ctrl,
    output svcrc_pkg::svcrc_status_s           o_status,
    output svcrc_pkg::svcrc_sched_e            o_scheme,
    output logic      [7:0]                    o_class_enable
);
    localparam int TBITS = PHASES * PHASE_BITS;

    // byte-enable expansion, used for the write mask only
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction : hit

    svcrc_pkg::svcrc_ctrl_s   ctrl_reg;
    svcrc_pkg::svcrc_ctrl_s   ctrl_next;
    svcrc_pkg::svcrc_status_s stat_reg;
    svcrc_pkg::svcrc_status_s stat_next;
    svcrc_pkg::svcrc_neg_e    neg_reg;
    svcrc_pkg::svcrc_neg_e    neg_next;
    logic [31:0]              rdata_reg;
    logic [31:0]              rdata_next;
    logic                     neg_done_s1;
    logic                     neg_done_s2;
    logic                     ctrl_wr;
    logic [31:0]              wmask;
    logic [31:0]              wval;
    logic [31:0]              ctrl_word;
    logic                     apply_start;
    logic                     apply_done;
    logic                     apply_busy;
    logic                     en_wr;

    assign ctrl_wr     = i_cfg_wr && hit(i_cfg_addr, `SVCRC_CTRL_OFFSET);
    assign wmask       = be_mask(i_cfg_be) & `SVCRC_CTRL_WMASK;
    assign wval        = i_cfg_wdata;
    assign apply_start = ctrl_wr && i_cfg_be[2] && wval[`SVCRC_APPLY_BIT];
    assign en_wr       = ctrl_wr && wmask[`SVCRC_EN_BIT] && wval[`SVCRC_EN_BIT];

    // apply bit never stored, reserved bits never stored
    assign ctrl_word = {ctrl_reg.enable, 4'h0, ctrl_reg.identifier, 4'h0,
                        ctrl_reg.scheme_select, 1'b0, 8'h00, ctrl_reg.class_map};

    // control fields
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr)
        begin
            if (wmask[`SVCRC_EN_BIT])
            begin
                ctrl_next.enable = wval[`SVCRC_EN_BIT];
            end
            // reserved identifier write keeps the old value
            if (wmask[`SVCRC_ID_LSB] &&
                wval[`SVCRC_ID_MSB:`SVCRC_ID_LSB] != `SVCRC_ID_RESERVED)
            begin
                ctrl_next.identifier = wval[`SVCRC_ID_MSB:`SVCRC_ID_LSB];
            end
            if (wmask[`SVCRC_SEL_LSB])
            begin
                ctrl_next.scheme_select = wval[`SVCRC_SEL_MSB:`SVCRC_SEL_LSB];
            end
            if (wmask[1])
            begin
                ctrl_next.class_map = {wval[`SVCRC_MAP_MSB:1], 1'b0};
            end
        end
    end

    // negotiation state
    always_comb
    begin
        neg_next = neg_reg;
        case (neg_reg)
            svcrc_pkg::NEG_IDLE:
            begin
                if (en_wr)
                begin
                    neg_next = svcrc_pkg::NEG_REQ;
                end
            end
            svcrc_pkg::NEG_REQ:
            begin
                neg_next = svcrc_pkg::NEG_WAIT;
            end
            svcrc_pkg::NEG_WAIT:
            begin
                if (neg_done_s2)
                begin
                    neg_next = svcrc_pkg::NEG_IDLE;
                end
            end
            default:
            begin
                neg_next = svcrc_pkg::NEG_IDLE;
            end
        endcase
    end

    // status flags; the setting event wins over the clearing one
    always_comb
    begin
        stat_next = stat_reg;
        stat_next.negotiation_pending = (neg_next != svcrc_pkg::NEG_IDLE);
        if (apply_done)
        begin
            stat_next.table_status = 1'b0;
        end
        if (i_table_modified)
        begin
            stat_next.table_status = 1'b1;
        end
    end

    // read data
    always_comb
    begin
        rdata_next = rdata_reg;
        if (i_cfg_rd)
        begin
            if (hit(i_cfg_addr, `SVCRC_CTRL_OFFSET))
            begin
                rdata_next = ctrl_word;
            end
            else if (hit(i_cfg_addr, `SVCRC_STATUS_OFFSET))
            begin
                rdata_next = {14'h0000, stat_reg.negotiation_pending,
                              stat_reg.table_status, 16'h0000};
            end
            else if (hit(i_cfg_addr, `SVCRC_CAP_OFFSET))
            begin
                rdata_next = {24'h00_0000, `SVCRC_ARB_CAP};
            end
            else
            begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            ctrl_reg.enable        <= 1'b0;
            ctrl_reg.identifier    <= `SVCRC_ID_RESET;
            ctrl_reg.scheme_select <= `SVCRC_SEL_RR;
            ctrl_reg.class_map     <= `SVCRC_MAP_RESET;
            stat_reg               <= '0;
            neg_reg                <= svcrc_pkg::NEG_IDLE;
            rdata_reg              <= 32'h0000_0000;
            neg_done_s1            <= 1'b0;
            neg_done_s2            <= 1'b0;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            stat_reg    <= stat_next;
            neg_reg     <= neg_next;
            rdata_reg   <= rdata_next;
            neg_done_s1 <= i_neg_done;
            neg_done_s2 <= neg_done_s1;
        end
    end

    svcrc_apply_seq #(
        .TABLE_BITS (TBITS)
    ) u_apply (
        .i_sys_clk      (i_sys_clk),
        .i_reset        (i_reset),
        .i_start        (apply_start),
        .i_shadow_table (i_shadow_table),
        .o_active_table (o_active_table),
        .o_busy         (apply_busy),
        .o_done         (apply_done)
    );

    // per-class enable, class zero never here
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_class
            assign o_class_enable[gi] = ctrl_reg.class_map[gi];
        end
    endgenerate

    assign o_scheme = (ctrl_reg.scheme_select == `SVCRC_SEL_TWRR) ?
                      svcrc_pkg::SCH_TWRR : svcrc_pkg::SCH_RR;
    assign o_neg_start = (neg_reg == svcrc_pkg::NEG_REQ);
    assign o_cfg_rdata = rdata_reg;
    assign o_ctrl      = ctrl_reg;
    assign o_status    = stat_reg;

    sequence s_enable_write;
        en_wr && neg_reg == svcrc_pkg::NEG_IDLE;
    endsequence

    sequence s_apply_launch;
        apply_start && !apply_busy;
    endsequence

    // negotiation, identifier, reserved bit, class map, reset value and table status checks
    a_enable_pend: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        s_enable_write |=> (stat_reg.negotiation_pending && o_neg_start))
        else $error("enable write did not start negotiation");
    a_pend_holds: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (neg_reg == svcrc_pkg::NEG_WAIT && !neg_done_s2) |=> stat_reg.negotiation_pending)
        else $error("pending dropped during negotiation");
    a_pend_clears: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (neg_reg == svcrc_pkg::NEG_WAIT && neg_done_s2) |=> !stat_reg.negotiation_pending)
        else $error("pending not cleared after negotiation");
    a_id_nonzero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ctrl_reg.identifier != `SVCRC_ID_RESERVED)
        else $error("identifier holds reserved zero");
    a_rsvd_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (ctrl_word & ~`SVCRC_CTRL_WMASK) == 32'h0000_0000)
        else $error("reserved or strobe bits read non-zero");
    a_map_bit0: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !o_class_enable[0])
        else $error("class zero mapped");
    a_reset_val: assert property (@(posedge i_sys_clk)
        i_reset |=> ctrl_word == `SVCRC_CTRL_RESET)
        else $error("control reset value wrong");
    a_tbl_status: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_table_modified |=> stat_reg.table_status)
        else $error("table status not set by edit");
    a_tbl_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (apply_done && !i_table_modified) |=> !stat_reg.table_status)
        else $error("table status not cleared by load");
    // start pulse, scheme decode, readback and apply launch checks
    a_start_pulse: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_neg_start |=> !o_neg_start)
        else $error("negotiation start longer than one cycle");
    a_pend_on_start: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_neg_start |-> stat_reg.negotiation_pending)
        else $error("start without pending");
    a_wait_no_start: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        neg_reg == svcrc_pkg::NEG_WAIT |-> !o_neg_start)
        else $error("negotiation restarted while pending");
    a_sched_twrr: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ctrl_reg.scheme_select == `SVCRC_SEL_TWRR |-> o_scheme == svcrc_pkg::SCH_TWRR)
        else $error("select four not decoded as timed scheme");
    a_sched_rr: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        ctrl_reg.scheme_select == `SVCRC_SEL_RR |-> o_scheme == svcrc_pkg::SCH_RR)
        else $error("select zero not decoded as round-robin");
    a_strobe_read: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_cfg_rd && hit(i_cfg_addr, `SVCRC_CTRL_OFFSET)) |=> !o_cfg_rdata[`SVCRC_APPLY_BIT])
        else $error("apply strobe read back as one");
    a_cap_read: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_cfg_rd && hit(i_cfg_addr, `SVCRC_CAP_OFFSET)) |=> o_cfg_rdata == {24'h00_0000, `SVCRC_ARB_CAP})
        else $error("capability readback wrong");
    a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !i_cfg_rd |=> $stable(o_cfg_rdata))
        else $error("read data changed without a read");
    a_apply_launch: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        s_apply_launch |=> apply_busy)
        else $error("apply write did not start the copy");
endmodule : svcrc_ctrl

/* File: core/svcrc_params.svh */
// offsets, field positions, reset values and timing counts for the second channel control
`ifndef SVCRC_PARAMS_SVH
`define SVCRC_PARAMS_SVH
`define SVCRC_CTRL_OFFSET     12'h0170
`define SVCRC_STATUS_OFFSET   12'h0176
`define SVCRC_CAP_OFFSET      12'h016C
`define SVCRC_CTRL_RESET      32'h0100_0000
`define SVCRC_CTRL_WMASK      32'h870E_00FE
`define SVCRC_EN_BIT          31
`define SVCRC_ID_MSB          26
`define SVCRC_ID_LSB          24
`define SVCRC_SEL_MSB         19
`define SVCRC_SEL_LSB         17
`define SVCRC_APPLY_BIT       16
`define SVCRC_MAP_MSB         7
`define SVCRC_MAP_LSB         0
`define SVCRC_ID_RESET        3'h1
`define SVCRC_ID_RESERVED     3'h0
`define SVCRC_SEL_RR          3'h0
`define SVCRC_SEL_TWRR        3'h4
`define SVCRC_MAP_RESET       8'h00
`define SVCRC_ARB_CAP         8'h11
`define SVCRC_TWRR_PHASES     128
`define SVCRC_APPLY_CYCLES    4'h4
`endif

/* File: core/svcrc_pkg.sv */
// types shared by the second channel control block
package svcrc_pkg;
    typedef enum logic [1:0] {NEG_IDLE, NEG_REQ, NEG_WAIT} svcrc_neg_e;
    typedef enum logic [0:0] {SCH_RR, SCH_TWRR} svcrc_sched_e;
    typedef struct packed {
        logic       enable;
        logic [2:0] identifier;
        logic [2:0] scheme_select;
        logic [7:0] class_map;
    } svcrc_ctrl_s;
    typedef struct packed {
        logic       negotiation_pending;
        logic       table_status;
    } svcrc_status_s;
endpackage : svcrc_pkg

/* File: core/svcrc_apply_seq.sv */
// copy sequencer that moves the shadow port table into the active table
`timescale 1ns/1ns
`include "svcrc_params.svh"
module svcrc_apply_seq #(
    parameter int TABLE_BITS = 512
) (
    // clock and reset
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset,
    // control
    input  wire logic                  i_start,
    input  wire logic [TABLE_BITS-1:0] i_shadow_table,
    output logic      [TABLE_BITS-1:0] o_active_table,
    output logic                       o_busy,
    output logic                       o_done
);
    logic [3:0]            cnt_reg;
    logic [3:0]            cnt_next;
    logic                  busy_reg;
    logic                  busy_next;
    logic                  done_reg;
    logic                  done_next;
    logic [TABLE_BITS-1:0] table_reg;
    logic [TABLE_BITS-1:0] table_next;

    always_comb
    begin
        cnt_next   = cnt_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        table_next = table_reg;
        if (i_start && !busy_reg)
        begin
            busy_next = 1'b1;
            cnt_next  = `SVCRC_APPLY_CYCLES;
        end
        else if (busy_reg)
        begin
            cnt_next = cnt_reg - 4'h1;
            if (cnt_reg == 4'h1)
            begin
                table_next = i_shadow_table;
                busy_next  = 1'b0;
                done_next  = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            cnt_reg   <= 4'h0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            table_reg <= '0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
            table_reg <= table_next;
        end
    end

    assign o_active_table = table_reg;
    assign o_busy         = busy_reg;
    assign o_done         = done_reg;

    a_apply_copy: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_start && !busy_reg) |-> ##5 (done_reg && table_reg == $past(i_shadow_table)))
        else $error("table copy not finished on time");
endmodule : svcrc_apply_seq

/* File: tb/svcrc_link_model.sv */
// link partner model that answers a negotiation request after a delay
`timescale 1ns/1ns
module svcrc_link_model #(
    parameter int DONE_DELAY = 20
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    // negotiation handshake
    input  wire logic i_neg_start,
    output logic      o_neg_done
);
    int  count_reg;
    logic busy_reg;

    // one done pulse per request, DONE_DELAY+1 cycles after the start is sampled
    always @(posedge i_sys_clk)
    begin
        o_neg_done <= 1'b0;
        if (i_reset)
        begin
            busy_reg  <= 1'b0;
            count_reg <= 0;
        end
        else if (i_neg_start && !busy_reg)
        begin
            busy_reg  <= 1'b1;
            count_reg <= 0;
        end
        else if (busy_reg)
        begin
            count_reg <= count_reg + 1;
            if (count_reg == DONE_DELAY)
            begin
                o_neg_done <= 1'b1;
                busy_reg   <= 1'b0;
            end
        end
    end
endmodule : svcrc_link_model

/* File: tb/svcrc_ctrl_tb.sv */
// self-checking testbench for the second channel control register
`timescale 1ns/1ns
`include "svcrc_params.svh"
module svcrc_ctrl_tb;
    logic                     i_sys_clk = 1'b0;
    logic                     i_reset = 1'b1;
    logic                     i_cfg_wr = 1'b0;
    logic                     i_cfg_rd = 1'b0;
    logic [11:0]              i_cfg_addr = 12'h000;
    logic [3:0]               i_cfg_be = 4'h0;
    logic [31:0]              i_cfg_wdata = 32'h0000_0000;
    logic [31:0]              o_cfg_rdata;
    logic                     o_neg_start;
    logic                     i_neg_done;
    logic                     i_table_modified = 1'b0;
    logic [511:0]             i_shadow_table = '0;
    logic [511:0]             o_active_table;
    svcrc_pkg::svcrc_ctrl_s   o_ctrl;
    svcrc_pkg::svcrc_status_s o_status;
    svcrc_pkg::svcrc_sched_e  o_scheme;
    logic [7:0]               o_class_enable;
    logic [31:0]              rd;
    int                       mismatches = 0;
    int                       cmp_count = 0;
    int                       cycles = 0;
    int                       i;

    svcrc_ctrl dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_cfg_wr(i_cfg_wr),
        .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_neg_start(o_neg_start),
        .i_neg_done(i_neg_done), .i_table_modified(i_table_modified),
        .i_shadow_table(i_shadow_table), .o_active_table(o_active_table), .o_ctrl(o_ctrl),
        .o_status(o_status), .o_scheme(o_scheme), .o_class_enable(o_class_enable));

    svcrc_link_model partner (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_neg_start(o_neg_start), .o_neg_done(i_neg_done));

    initial
    begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    always @(posedge i_sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            $display("mismatch at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cfg_write(input logic [11:0] addr, input logic [3:0] be,
                             input logic [31:0] data);
        @(posedge i_sys_clk);
        i_cfg_wr    <= 1'b1;
        i_cfg_addr  <= addr;
        i_cfg_be    <= be;
        i_cfg_wdata <= data;
        @(posedge i_sys_clk);
        i_cfg_wr    <= 1'b0;
        #1;
    endtask : cfg_write

    task automatic cfg_read(input logic [11:0] addr, output logic [31:0] data);
        @(posedge i_sys_clk);
        i_cfg_rd   <= 1'b1;
        i_cfg_addr <= addr;
        @(posedge i_sys_clk);
        i_cfg_rd   <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        data = o_cfg_rdata;
    endtask : cfg_read

    initial
    begin
        repeat (8) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        // reset values, capability and unmapped space
        cfg_read(`SVCRC_CTRL_OFFSET, rd);
        check(rd, `SVCRC_CTRL_RESET);
        check({29'h0, o_ctrl.scheme_select}, {29'h0, `SVCRC_SEL_RR});
        cfg_read(12'h174, rd);
        check(rd, 32'h0000_0000);
        cfg_read(`SVCRC_CAP_OFFSET, rd);
        check({24'h0, rd[7:0]}, {24'h0, `SVCRC_ARB_CAP});
        cfg_read(12'h200, rd);
        check(rd, 32'h0000_0000);
        $display("test reset done");
        // all writable bits except enable and select bits 18:17, and all reserved bits, select four
        cfg_write(`SVCRC_CTRL_OFFSET, 4'hF, 32'h7FF8_FFFF);
        cfg_read(`SVCRC_CTRL_OFFSET, rd);
        check(rd, 32'h0708_00FE);
        check({24'h0, o_class_enable}, 32'h0000_00FE);
        check({31'h0, o_scheme == svcrc_pkg::SCH_TWRR}, 32'h1);
        cfg_write(`SVCRC_CTRL_OFFSET, 4'hF, 32'h0700_0012);
        check({31'h0, o_scheme == svcrc_pkg::SCH_RR}, 32'h1);
        check({24'h0, o_class_enable}, 32'h0000_0012);
        $display("test fields done");
        // every legal identifier, then the reserved one
        for (i = 1; i < 8; i++)
        begin
            cfg_write(`SVCRC_CTRL_OFFSET, 4'hF, {5'h0, 3'(i), 24'h00_0000});
            cfg_read(`SVCRC_CTRL_OFFSET, rd);
            check(rd, {5'h0, 3'(i), 24'h00_0000});
        end
        cfg_write(`SVCRC_CTRL_OFFSET, 4'hF, 32'h0000_0000);
        cfg_read(`SVCRC_CTRL_OFFSET, rd);
        check(rd, 32'h0700_0000);
        $display("test identifier done");
        // negotiation start, pending, and finish
        cfg_write(`SVCRC_CTRL_OFFSET, 4'hF, 32'h8100_0000);
        check({31'h0, o_neg_start}, 32'h1);
        cfg_read(12'h174, rd);
        check(rd, 32'h0002_0000);
        cfg_write(`SVCRC_CTRL_OFFSET, 4'hF, 32'h8100_0000);
        check({31'h0, o_neg_start}, 32'h0);
        for (i = 0; i < 60 && o_status.negotiation_pending !== 1'b0; i++)
            @(posedge i_sys_clk);
        #1;
        check({31'h0, o_status.negotiation_pending}, 32'h0);
        cfg_read(`SVCRC_CTRL_OFFSET, rd);
        check(rd, 32'h8100_0000);
        $display("test negotiation done");
        // table edit sets status, apply copies table and clears it
        @(posedge i_sys_clk);
        i_shadow_table   <= {128{4'h5}} ^ {16{32'h0123_4567}};
        i_table_modified <= 1'b1;
        @(posedge i_sys_clk);
        i_table_modified <= 1'b0;
        cfg_read(12'h174, rd);
        check(rd, 32'h0001_0000);
        check({31'h0, o_active_table == 512'h0}, 32'h1);
        cfg_write(`SVCRC_CTRL_OFFSET, 4'h4, 32'h0001_0000);
        repeat (6) @(posedge i_sys_clk);
        #1;
        check({31'h0, o_active_table === i_shadow_table}, 32'h1);
        check({31'h0, o_status.table_status}, 32'h0);
        cfg_read(`SVCRC_CTRL_OFFSET, rd);
        check(rd, 32'h8100_0000);
        $display("test table apply done");
        end_of_test();
    end
endmodule : svcrc_ctrl_tb
